// ---- design/fsi_pkg.sv ----
// Purpose: shared constants and types for the fan floor step interval block
// Assumes: 32-bit APB, one word per register
// Notes: printed offsets are word indices; the byte address is four times the index
package fsi_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	// word indices; 0x036 is not word aligned, so it cannot be a byte address
	localparam logic [11:0] STEP_INTERVAL_IDX = 12'h036;
	localparam logic [11:0] DYN_CTRL2_IDX = 12'h050;
	localparam logic [11:0] LOCK_CTRL_IDX = 12'h040;
	localparam logic [11:0] STATUS_IDX = 12'h100;
	// byte addresses on the bus, one aligned word per register
	localparam logic [11:0] STEP_INTERVAL_OFS = {STEP_INTERVAL_IDX[9:0], 2'b00};
	localparam logic [11:0] DYN_CTRL2_OFS = {DYN_CTRL2_IDX[9:0], 2'b00};
	localparam logic [11:0] LOCK_CTRL_OFS = {LOCK_CTRL_IDX[9:0], 2'b00};
	localparam logic [11:0] STATUS_OFS = {STATUS_IDX[9:0], 2'b00};

	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] STEP_INTERVAL_RST = 8'h00;
	localparam logic [7:0] DYN_CTRL2_RST = 8'h00;
	localparam logic [7:0] LOCK_CTRL_RST = 8'h00;
	localparam int REMOTE1_LSB = 0;
	localparam int LOCAL_LSB = 3;
	localparam int REMOTE2_LO_LSB = 6;
	localparam int REMOTE2_HI_BIT = 0;
	localparam int LOCK_BIT = 1;
	localparam int NUM_CHAN = 3;

	// ----------------------------------------
	// interval counts in monitoring cycles
	// ----------------------------------------
	localparam logic [11:0] DEC_BASE_CYCLES = 12'h008;
	localparam int CNT_W = 12;

	// per-channel adjustment requests and grants
	typedef struct packed {
		logic dec;
		logic inc;
	} fsi_adj_s;
endpackage

// ---- design/fsi_apb_slave.sv ----
// Purpose: apb slave front end, one-cycle access with zero wait states
// Assumes: 32-bit apb, single clock
// Notes: decodes word offsets, flags unmapped addresses with pslverr
`timescale 1ns/100ps
module fsi_apb_slave (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	output logic pready,
	output logic pslverr,
	// register access strobes
	output logic wr_stb,
	output logic rd_stb,
	output logic [11:0] acc_addr,
	input wire logic addr_hit
);
	logic pready_reg;
	logic pslverr_reg;

	// ready stands for the access cycle after every setup, so no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= psel & ~penable;
		end
	end
	assign pready = pready_reg;

	// error decided in setup so it stands only in the access cycle of an unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= psel & ~penable & ~addr_hit;
		end
	end
	assign pslverr = pslverr_reg;
	// strobes in the access phase, the one edge where the master commits
	assign wr_stb = psel & penable & pwrite & addr_hit;
	assign rd_stb = psel & penable & ~pwrite & addr_hit;
	assign acc_addr = {paddr[11:2], 2'b00};
endmodule

// ---- design/fsi_interval_timer.sv ----
// Purpose: one channel's decrease and increase interval counters
// Assumes: mon_tick is a one-cycle pulse per monitoring cycle
// Notes: counters saturate so a long wait never wraps to a false short one
`timescale 1ns/100ps
module fsi_interval_timer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic mon_tick,
	input wire logic [2:0] code,
	input wire fsi_pkg::fsi_adj_s req,
	// result
	output fsi_pkg::fsi_adj_s allow
);
	logic [fsi_pkg::CNT_W-1:0] dec_cnt_reg;
	logic [fsi_pkg::CNT_W-1:0] inc_cnt_reg;
	logic [fsi_pkg::CNT_W-1:0] dec_lim;
	logic [fsi_pkg::CNT_W-1:0] inc_lim;
	logic dec_ok;
	logic inc_ok;

	// R05: 8 << n decrease
	assign dec_lim = fsi_pkg::DEC_BASE_CYCLES << code;
	// R06: increase doubles decrease
	assign inc_lim = dec_lim << 1;
	assign dec_ok = dec_cnt_reg >= dec_lim;
	assign inc_ok = inc_cnt_reg >= inc_lim;

	// R10: permit after elapsed interval
	always_comb begin
		allow.dec = req.dec & dec_ok;
		allow.inc = req.inc & inc_ok;
	end

	// R10: count cycles since decrease
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_cnt_reg <= '0;
		end else if (allow.dec) begin
			dec_cnt_reg <= '0;
		end else if (mon_tick && !dec_ok) begin
			dec_cnt_reg <= dec_cnt_reg + 1'b1;
		end
	end

	// R10: count cycles since increase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inc_cnt_reg <= '0;
		end else if (allow.inc) begin
			inc_cnt_reg <= '0;
		end else if (mon_tick && !inc_ok) begin
			inc_cnt_reg <= inc_cnt_reg + 1'b1;
		end
	end
endmodule

// ---- design/fsi_top.sv ----
// Purpose: fan floor step interval register and per-channel pacing
// Assumes: apb master in pclk domain, monitoring tick from the loop logic
// Notes: lock clears only by reset
// Operation
// R01: register read-only once lock bit set
// R02: writes after lock ignored until reset
// R03: register resets to zero
// R04: bits 2:0 remote1 interval code
// R05: decrease interval is 8 shifted by code
// R06: increase interval twice the decrease interval
// R07: bits 5:3 local interval code
// R08: software picks codes per thermal time constants
// R09: bits 7:6 remote2 low code bits
// R10: per-channel counters gate each adjustment
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module fsi_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// control loop side, same clock
	input wire logic mon_tick,
	input wire fsi_pkg::fsi_adj_s [2:0] adj_req,
	output fsi_pkg::fsi_adj_s [2:0] adj_allow
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] step_interval_reg;
	logic [7:0] dyn_ctrl2_reg;
	logic [7:0] lock_ctrl_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	fsi_pkg::fsi_adj_s [2:0] adj_allow_reg;
	fsi_pkg::fsi_adj_s [2:0] allow_comb;
	logic [2:0] chan_code [3];
	logic wr_stb;
	logic [11:0] acc_addr;
	logic addr_hit;
	logic locked;

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	assign addr_hit = (acc_addr == fsi_pkg::STEP_INTERVAL_OFS) || (acc_addr == fsi_pkg::DYN_CTRL2_OFS)
		|| (acc_addr == fsi_pkg::LOCK_CTRL_OFS) || (acc_addr == fsi_pkg::STATUS_OFS);

	fsi_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.wr_stb(wr_stb),
		.rd_stb(),
		.acc_addr(acc_addr),
		.addr_hit(addr_hit)
	);

	assign locked = lock_ctrl_reg[fsi_pkg::LOCK_BIT];

	// lock bit is sticky; only reset clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_ctrl_reg <= fsi_pkg::LOCK_CTRL_RST;
		end else if (wr_stb && acc_addr == fsi_pkg::LOCK_CTRL_OFS) begin
			lock_ctrl_reg <= lock_ctrl_reg | pwdata[7:0];
		end
	end

	// R03: reset value zero
	// R01: write blocked when locked
	// R02: later writes ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_interval_reg <= fsi_pkg::STEP_INTERVAL_RST;
		end else if (wr_stb && !locked && acc_addr == fsi_pkg::STEP_INTERVAL_OFS) begin
			step_interval_reg <= pwdata[7:0];
		end
	end

	// companion register holding the remote2 code msb, same lock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dyn_ctrl2_reg <= fsi_pkg::DYN_CTRL2_RST;
		end else if (wr_stb && !locked && acc_addr == fsi_pkg::DYN_CTRL2_OFS) begin
			dyn_ctrl2_reg <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// read data registered; the master samples it at the access edge, one edge after setup
	always_comb begin
		prdata_next = 32'h0000_0000;
		case (acc_addr)
			fsi_pkg::STEP_INTERVAL_OFS: prdata_next = {24'h00_0000, step_interval_reg};
			fsi_pkg::DYN_CTRL2_OFS: prdata_next = {24'h00_0000, dyn_ctrl2_reg};
			fsi_pkg::LOCK_CTRL_OFS: prdata_next = {24'h00_0000, lock_ctrl_reg};
			fsi_pkg::STATUS_OFS: prdata_next = {26'h000_0000, adj_allow_reg[2].dec, adj_allow_reg[2].inc,
				adj_allow_reg[1].dec, adj_allow_reg[1].inc, adj_allow_reg[0].dec, adj_allow_reg[0].inc};
			default: prdata_next = 32'h0000_0000;
		endcase
	end

	// loaded in setup phase so data is valid at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= prdata_next;
		end
	end
	assign prdata = prdata_reg;

	// ----------------------------------------
	// channel codes and pacing
	// ----------------------------------------
	// R04: remote1 code
	assign chan_code[0] = step_interval_reg[fsi_pkg::REMOTE1_LSB +: 3];
	// R07: local code
	assign chan_code[1] = step_interval_reg[fsi_pkg::LOCAL_LSB +: 3];
	// R09: remote2 split code
	assign chan_code[2] = {dyn_ctrl2_reg[fsi_pkg::REMOTE2_HI_BIT], step_interval_reg[fsi_pkg::REMOTE2_LO_LSB +: 2]};

	// one pacing timer per channel, same encoding for all
	for (genvar g = 0; g < fsi_pkg::NUM_CHAN; g++) begin : g_chan
		fsi_interval_timer u_timer (
			.pclk(pclk),
			.presetn(presetn),
			.mon_tick(mon_tick),
			.code(chan_code[g]),
			.req(adj_req[g]),
			.allow(allow_comb[g])
		);
	end

	// grants registered so outputs come from flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adj_allow_reg <= '0;
		end else begin
			adj_allow_reg <= allow_comb;
		end
	end
	assign adj_allow = adj_allow_reg;
endmodule

// ---- tb/fsi_top_monitor.sv ----
// Purpose: port checks for fsi_top
// Assumes: one pclk domain, tick at most once a cycle
// Notes: bound after the module
`timescale 1ns/100ps
module fsi_top_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// loop side
	input wire fsi_pkg::fsi_adj_s [2:0] adj_req,
	input wire fsi_pkg::fsi_adj_s [2:0] adj_allow
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a grant needs at least eight cycles before the next
	sequence dec_quiet;
		!adj_allow[0].dec [*7];
	endsequence
	a_err_in_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped data");
	a_first_wait: assert property ($rose(presetn) |-> !adj_allow[0].dec [*8]) else $error("early grant");
	a_dec_gap: assert property (adj_allow[0].dec |=> dec_quiet) else $error("dec gap short");
	a_inc_gap: assert property (adj_allow[1].inc |=> !adj_allow[1].inc [*8]) else $error("inc gap short");
	a_dec_cause: assert property (adj_allow[1].dec |-> $past(adj_req[1].dec)) else $error("dec unasked");
	a_inc_cause: assert property (adj_allow[2].inc |-> $past(adj_req[2].inc)) else $error("inc unasked");
	a_grant_once: assert property (adj_allow[2].dec |=> !adj_allow[2].dec) else $error("grant held");
endmodule
bind fsi_top fsi_top_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pslverr, .adj_req,
	.adj_allow);

// ---- tb/fsi_top_test.sv ----
// Purpose: self-checking bench for fsi_top
// Assumes: tick every other cycle, so gaps are twice the count
// Notes: gaps get a few cycles of slack for grant latency
`timescale 1ns/100ps
module fsi_top_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mon_tick = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'he9c23a36;
	logic pready, pslverr;
	fsi_pkg::fsi_adj_s [2:0] adj_req = '0;
	fsi_pkg::fsi_adj_s [2:0] adj_allow;
	int miscompares = 0, cmp_count = 0, cyc = 0;
	fsi_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mon_tick, .adj_req, .adj_allow);
	// ----
	// clock, tick, hang guard
	// ----
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		mon_tick <= ~mon_tick;
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			give_verdict();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// spacing window in cycles for a count of ticks
	function automatic logic [31:0] in_gap(input int g, input int lim);
		return {31'h0, g >= 2 * lim - 2 && g <= 2 * lim + 4};
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one apb transfer; holds the request until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// time two successive grants of each direction on one channel
	task automatic meas(input int ch, input int code);
		int nd, ni, td, ti, gd, gi;
		@(posedge pclk);
		adj_req[ch] <= 2'b11;
		for (int n = 0; n < 9000 && (nd < 2 || ni < 2); n++) begin
			@(posedge pclk);
			#1;
			if (adj_allow[ch].dec === 1'b1) begin
				gd = n - td;
				td = n;
				nd++;
			end
			if (adj_allow[ch].inc === 1'b1) begin
				gi = n - ti;
				ti = n;
				ni++;
			end
		end
		@(posedge pclk);
		adj_req[ch] <= 2'b00;
		chk("dec gap", in_gap(gd, 8 << code), 32'h1);
		chk("inc gap", in_gap(gi, 16 << code), 32'h1);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, fsi_pkg::STEP_INTERVAL_OFS, 0);
		chk("step reset", rd, 32'h0);
		apb(0, 12'h0f0, 0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		// random words, only the low byte is kept
		repeat (8) begin
			seed = lfsr(seed);
			apb(1, fsi_pkg::STEP_INTERVAL_OFS, seed);
			apb(0, fsi_pkg::STEP_INTERVAL_OFS, 0);
			chk("step rw", rd, {24'h0, seed[7:0]});
		end
		for (int c = 0; c < 8; c++) begin
			apb(1, fsi_pkg::STEP_INTERVAL_OFS, c);
			meas(0, c);
		end
		// per-channel codes picked from the seed
		seed = lfsr(seed);
		apb(1, fsi_pkg::STEP_INTERVAL_OFS, {26'h0, seed[2:0], 3'h0});
		meas(1, seed[2:0]);
		apb(1, fsi_pkg::STEP_INTERVAL_OFS, {24'h0, seed[5:4], 6'h0});
		apb(1, fsi_pkg::DYN_CTRL2_OFS, {31'h0, seed[6]});
		meas(2, {seed[6], seed[5:4]});
		// lock, then both writes must bounce
		apb(1, fsi_pkg::LOCK_CTRL_OFS, 32'h2);
		apb(1, fsi_pkg::STEP_INTERVAL_OFS, 32'hff);
		apb(1, fsi_pkg::DYN_CTRL2_OFS, {31'h0, ~seed[6]});
		apb(0, fsi_pkg::STEP_INTERVAL_OFS, 0);
		chk("locked step", rd, {24'h0, seed[5:4], 6'h0});
		apb(0, fsi_pkg::DYN_CTRL2_OFS, 0);
		chk("locked dyn", rd, {31'h0, seed[6]});
		apb(0, fsi_pkg::LOCK_CTRL_OFS, 0);
		chk("lock bit", rd, 32'h2);
		// mid-run reset clears the lock and reloads zero
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, fsi_pkg::STEP_INTERVAL_OFS, 0);
		chk("step after reset", rd, 32'h0);
		apb(0, fsi_pkg::STATUS_OFS, 0);
		chk("status idle", rd, 32'h0);
		apb(1, fsi_pkg::STEP_INTERVAL_OFS, 32'h15);
		apb(0, fsi_pkg::STEP_INTERVAL_OFS, 0);
		chk("unlocked step", rd, 32'h15);
		give_verdict();
	end
endmodule
